//--- hw/fcsm_top.sv
// command-decoding write state machine of a boot-block nor flash
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - byte codes select read, program, erase, suspend
// R02 - idle: 90 config, 98 query, 60 lock
// R03 - programming: busy status, only suspend acts
// R04 - program suspended status: ready, d0 resumes
// R05 - program suspended array: config, query, status
// R06 - program done: ready, decode like idle
// R07 - erase setup: only d0 starts erase
// R08 - erase error state decodes like idle
// R09 - erasing: busy status, only suspend acts
// R10 - erase suspended: ready, program, lock allowed
// R11 - erase suspended: lock codes to array
// R12 - erase suspended array: status, config, query
// R13 - write after program setup is data
// R14 - host polls ready before new commands
// R15 - array read after reset release
module fcsm_top
  import fcsm_pkg::*;
(
  input  wire logic              mclk,              // 125 mhz core clock
  input  wire logic              sys_rst,           // async reset, high
  input  wire logic              wr_stb,            // one bus write taken
  input  wire logic [DATA_W-1:0] wr_data,           // written word
  input  wire logic              op_done,           // algorithm finished
  output fcsm_src_t              read_src,          // what reads return
  output logic                   machine_ready_bit, // status ready flag
  output logic                   prog_suspended,    // program is parked
  output logic                   erase_suspended,   // erase is parked
  output fcsm_ctl_t              ctl,               // request pulses
  output logic [DATA_W-1:0]      op_data            // program data / code
);

  fcsm_regs_t r_reg;   // registered state
  fcsm_regs_t r_next;  // next state
  fcsm_cmd_t  cmd;     // class of the written byte

  // byte classifier
  fcsm_cmd_decode u_dec (
    .code (wr_data[CODE_W-1:0]),
    .cmd  (cmd)
  );

  // next state from any idle or completed state
  function automatic fcsm_state_t idle_next(input fcsm_cmd_t c);
    unique case (c)
      CMD_PG_SETUP:  idle_next = ST_PG_SETUP;   // R01
      CMD_ER_SETUP:  idle_next = ST_ER_SETUP;   // R01
      CMD_RD_STATUS: idle_next = ST_RD_STATUS;  // R01
      CMD_RD_CONFIG: idle_next = ST_RD_CONFIG;  // R02
      CMD_RD_QUERY:  idle_next = ST_RD_QUERY;   // R02
      CMD_LK_SETUP:  idle_next = ST_LK_SETUP;   // R02
      CMD_PR_SETUP:  idle_next = ST_PR_SETUP;
      // ff, 50, b0, d0, 01, 2f and unknown bytes
      default:       idle_next = ST_RD_ARRAY;   // R02
    endcase
  endfunction

  // decode while program is suspended
  function automatic fcsm_state_t psus_next(input fcsm_cmd_t c);
    unique case (c)
      CMD_CONFIRM:   psus_next = ST_PG_BUSY;    // R04
      CMD_RD_STATUS: psus_next = ST_PS_STATUS;  // R05
      CMD_RD_CONFIG: psus_next = ST_PS_CONFIG;  // R05
      CMD_RD_QUERY:  psus_next = ST_PS_QUERY;   // R05
      default:       psus_next = ST_PS_ARRAY;   // R04
    endcase
  endfunction

  // decode while erase is suspended
  function automatic fcsm_state_t esus_next(input fcsm_cmd_t c);
    unique case (c)
      CMD_CONFIRM:   esus_next = ST_ER_BUSY;    // R11
      CMD_PG_SETUP:  esus_next = ST_EP_SETUP;   // R10
      CMD_LK_SETUP:  esus_next = ST_ES_LOCK;    // R10
      CMD_RD_STATUS: esus_next = ST_ES_STATUS;  // R12
      CMD_RD_CONFIG: esus_next = ST_ES_CONFIG;  // R12
      CMD_RD_QUERY:  esus_next = ST_ES_QUERY;   // R12
      // ff, 20, 50, b0, c0, 01, 2f fall back to array
      default:       esus_next = ST_ES_ARRAY;   // R11
    endcase
  endfunction

  // read source belonging to a state
  function automatic fcsm_src_t src_of(input fcsm_state_t s);
    unique case (s)
      ST_RD_ARRAY, ST_PS_ARRAY, ST_ES_ARRAY:    src_of = SRC_ARRAY;
      ST_RD_CONFIG, ST_PS_CONFIG, ST_ES_CONFIG: src_of = SRC_CONFIG;
      ST_RD_QUERY, ST_PS_QUERY, ST_ES_QUERY:    src_of = SRC_QUERY;
      default:                                  src_of = SRC_STATUS;
    endcase
  endfunction

  // ready flag is low only while the algorithm runs
  function automatic logic ready_of(input fcsm_state_t s);
    ready_of = !(s inside {ST_PG_BUSY, ST_ER_BUSY, ST_PR_BUSY, ST_EP_BUSY});
  endfunction

  // next-state logic
  always_comb begin
    r_next     = r_reg;
    r_next.ctl = CTL_NONE;
    unique case (r_reg.st)
      // idle reads and completed operations
      ST_RD_ARRAY, ST_RD_STATUS, ST_RD_CONFIG, ST_RD_QUERY,
      ST_LK_ERR, ST_LK_DONE, ST_PR_DONE, ST_PG_DONE,
      ST_ER_ERR, ST_ER_DONE: begin
        if (wr_stb) begin
          r_next.st         = idle_next(cmd);                // R06 R08
          r_next.ctl.clr_go = (cmd == CMD_CLR_STATUS);
        end
      end
      // lock setup: confirm codes lock, others error
      ST_LK_SETUP: begin
        if (wr_stb) begin
          if (cmd inside {CMD_LK_CONF, CMD_LKDN_CONF, CMD_CONFIRM}) begin
            r_next.st          = ST_LK_DONE;
            r_next.ctl.lock_go = 1'b1;
            r_next.wdata       = wr_data;
          end else begin
            r_next.st = ST_LK_ERR;
          end
        end
      end
      // lock setup during erase suspend returns to suspend status
      ST_ES_LOCK: begin
        if (wr_stb) begin
          r_next.st          = ST_ES_STATUS;
          r_next.ctl.lock_go = (cmd inside {CMD_LK_CONF, CMD_LKDN_CONF, CMD_CONFIRM});
          r_next.wdata       = wr_data;
        end
      end
      // protection register data word
      ST_PR_SETUP: begin
        if (wr_stb) begin
          r_next.st          = ST_PR_BUSY;
          r_next.ctl.prot_go = 1'b1;
          r_next.wdata       = wr_data;
        end
      end
      // protection programming ignores all writes
      ST_PR_BUSY: begin
        if (op_done) begin
          r_next.st = ST_PR_DONE;
        end
      end
      // any next write is the program data
      ST_PG_SETUP, ST_EP_SETUP: begin
        if (wr_stb) begin
          r_next.st          = (r_reg.st == ST_PG_SETUP) ? ST_PG_BUSY : ST_EP_BUSY; // R13
          r_next.ctl.prog_go = 1'b1;                                              // R13
          r_next.wdata       = wr_data;                                           // R13
        end
      end
      // programming: completion wins over a same-cycle suspend
      ST_PG_BUSY: begin
        if (op_done) begin
          r_next.st = ST_PG_DONE;                            // R06
        end else if (wr_stb && cmd == CMD_SUSPEND) begin
          r_next.st          = ST_PS_STATUS;                 // R03
          r_next.ctl.susp_go = 1'b1;
        end
      end
      // program nested in erase suspend, not suspendable
      ST_EP_BUSY: begin
        if (op_done) begin
          r_next.st = ST_ES_STATUS;
        end
      end
      // program suspended reads
      ST_PS_STATUS, ST_PS_ARRAY, ST_PS_CONFIG, ST_PS_QUERY: begin
        if (wr_stb) begin
          r_next.st            = psus_next(cmd);             // R04 R05
          r_next.ctl.resume_go = (cmd == CMD_CONFIRM);       // R04
          r_next.ctl.clr_go    = (cmd == CMD_CLR_STATUS);
        end
      end
      // erase setup: only confirm starts
      ST_ER_SETUP: begin
        if (wr_stb) begin
          if (cmd == CMD_CONFIRM) begin
            r_next.st           = ST_ER_BUSY;                // R07
            r_next.ctl.erase_go = 1'b1;                      // R07
          end else begin
            r_next.st = ST_ER_ERR;                           // R07
          end
        end
      end
      // erasing: completion wins over a same-cycle suspend
      ST_ER_BUSY: begin
        if (op_done) begin
          r_next.st = ST_ER_DONE;
        end else if (wr_stb && cmd == CMD_SUSPEND) begin
          r_next.st          = ST_ES_STATUS;                 // R09
          r_next.ctl.susp_go = 1'b1;
        end
      end
      // erase suspended reads
      ST_ES_STATUS, ST_ES_ARRAY, ST_ES_CONFIG, ST_ES_QUERY: begin
        if (wr_stb) begin
          r_next.st            = esus_next(cmd);             // R10 R11 R12
          r_next.ctl.resume_go = (cmd == CMD_CONFIRM);       // R11
          r_next.ctl.clr_go    = (cmd == CMD_CLR_STATUS);
        end
      end
    endcase
    // outputs follow the next state so they line up with it
    r_next.src        = src_of(r_next.st);                   // R03 R04 R12
    r_next.ready      = ready_of(r_next.st);                 // R03 R09 R10
    r_next.prog_susp  = r_next.st inside {ST_PS_STATUS, ST_PS_ARRAY,
                                          ST_PS_CONFIG, ST_PS_QUERY};
    r_next.erase_susp = r_next.st inside {ST_ES_STATUS, ST_ES_ARRAY, ST_ES_CONFIG,
                                          ST_ES_QUERY, ST_ES_LOCK, ST_EP_SETUP,
                                          ST_EP_BUSY};
  end

  // state register, array read after reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg.st         <= ST_RD_ARRAY;                       // R15
      r_reg.src        <= SRC_ARRAY;                         // R15
      r_reg.ready      <= 1'b1;
      r_reg.prog_susp  <= 1'b0;
      r_reg.erase_susp <= 1'b0;
      r_reg.ctl        <= CTL_NONE;
      r_reg.wdata      <= WDATA_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // output drive, all from flops
  assign read_src          = r_reg.src;
  assign machine_ready_bit = r_reg.ready;
  assign prog_suspended    = r_reg.prog_susp;
  assign erase_suspended   = r_reg.erase_susp;
  assign ctl               = r_reg.ctl;
  assign op_data           = r_reg.wdata;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // helper: current state is an idle read, program done, erase error or erase done
  logic idle_st;
  assign idle_st = r_reg.st inside {ST_RD_ARRAY, ST_RD_STATUS, ST_RD_CONFIG,
                                    ST_RD_QUERY, ST_PG_DONE, ST_ER_ERR, ST_ER_DONE};

  sequence s_pg_setup_write;
    r_reg.st == ST_PG_SETUP && wr_stb;
  endsequence

  sequence s_pg_started;
    ctl.prog_go && r_reg.st == ST_PG_BUSY && op_data == $past(wr_data)
      ##1 !ctl.prog_go;
  endsequence

  sequence s_er_busy_suspend;
    r_reg.st == ST_ER_BUSY && wr_stb && cmd == CMD_SUSPEND && !op_done;
  endsequence

  a_idle_config_query: assert property ( // R02
    idle_st && wr_stb && (cmd == CMD_RD_CONFIG || cmd == CMD_RD_QUERY) |=>
      (read_src == (($past(cmd) == CMD_RD_CONFIG) ? SRC_CONFIG : SRC_QUERY)))
    else $error("config or query read not selected from idle");

  a_prog_busy_status: assert property ( // R03
    r_reg.st == ST_PG_BUSY |-> !machine_ready_bit && read_src == SRC_STATUS)
    else $error("programming does not show busy status");

  a_prog_ignores_cmd: assert property ( // R03
    r_reg.st == ST_PG_BUSY && !op_done && !(wr_stb && cmd == CMD_SUSPEND) |=>
      r_reg.st == ST_PG_BUSY && ctl == CTL_NONE)
    else $error("command acted during programming");

  a_psus_resume: assert property ( // R04
    r_reg.st == ST_PS_STATUS && wr_stb && cmd == CMD_CONFIRM |=>
      ctl.resume_go && !machine_ready_bit ##1 r_reg.st == ST_PG_BUSY)
    else $error("program resume failed");

  a_psus_array_status: assert property ( // R05
    r_reg.st == ST_PS_ARRAY && wr_stb && cmd == CMD_RD_STATUS |=>
      read_src == SRC_STATUS && machine_ready_bit && prog_suspended)
    else $error("suspended status read not selected");

  a_prog_done_ready: assert property ( // R06
    r_reg.st == ST_PG_BUSY && op_done |=>
      machine_ready_bit && read_src == SRC_STATUS ##1 ($stable(r_reg.st) || $past(wr_stb)))
    else $error("program completion not reported");

  a_erase_setup_err: assert property ( // R07
    r_reg.st == ST_ER_SETUP && wr_stb && cmd != CMD_CONFIRM |=>
      r_reg.st == ST_ER_ERR && read_src == SRC_STATUS && !ctl.erase_go)
    else $error("bad erase confirm not turned into error");

  a_erase_err_decode: assert property ( // R08
    r_reg.st == ST_ER_ERR && wr_stb && cmd == CMD_PG_SETUP |=> r_reg.st == ST_PG_SETUP)
    else $error("erase error state did not decode like idle");

  a_erase_suspend: assert property ( // R09
    s_er_busy_suspend |=> ctl.susp_go && machine_ready_bit && erase_suspended
      ##1 !ctl.susp_go)
    else $error("erase suspend not taken");

  a_esus_array: assert property ( // R11
    r_reg.st == ST_ES_STATUS && wr_stb && cmd inside {CMD_PR_SETUP, CMD_LK_CONF} |=>
      r_reg.st == ST_ES_ARRAY && read_src == SRC_ARRAY)
    else $error("erase suspend fallback to array failed");

  a_esus_status: assert property ( // R12
    r_reg.st == ST_ES_ARRAY && wr_stb && cmd == CMD_RD_STATUS |=>
      read_src == SRC_STATUS && machine_ready_bit)
    else $error("erase suspended status read not selected");

  a_prog_data_taken: assert property ( // R13
    s_pg_setup_write |=> s_pg_started)
    else $error("write after program setup not taken as data");

endmodule
`default_nettype wire

//--- inc/fcsm_pkg.sv
// shared codes, types and reset values of the flash command state machine
`default_nettype none
package fcsm_pkg;

  // bus and command widths
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;

  // command byte values seen on the low data lane
  localparam logic [CODE_W-1:0] CODE_READ_ARRAY  = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_PROG_SETUP  = 8'h40;
  localparam logic [CODE_W-1:0] CODE_PROG_ALT    = 8'h10;
  localparam logic [CODE_W-1:0] CODE_ERASE_SETUP = 8'h20;
  localparam logic [CODE_W-1:0] CODE_CONFIRM     = 8'hD0;
  localparam logic [CODE_W-1:0] CODE_SUSPEND     = 8'hB0;
  localparam logic [CODE_W-1:0] CODE_READ_STATUS = 8'h70;
  localparam logic [CODE_W-1:0] CODE_CLR_STATUS  = 8'h50;
  localparam logic [CODE_W-1:0] CODE_READ_CONFIG = 8'h90;
  localparam logic [CODE_W-1:0] CODE_READ_QUERY  = 8'h98;
  localparam logic [CODE_W-1:0] CODE_LOCK_SETUP  = 8'h60;
  localparam logic [CODE_W-1:0] CODE_PROT_SETUP  = 8'hC0;
  localparam logic [CODE_W-1:0] CODE_LOCK_CONF   = 8'h01;
  localparam logic [CODE_W-1:0] CODE_LOCKDN_CONF = 8'h2F;

  // decoded command classes
  typedef enum logic [3:0] {
    CMD_RD_ARRAY, CMD_PG_SETUP, CMD_ER_SETUP, CMD_CONFIRM, CMD_SUSPEND,
    CMD_RD_STATUS, CMD_CLR_STATUS, CMD_RD_CONFIG, CMD_RD_QUERY,
    CMD_LK_SETUP, CMD_PR_SETUP, CMD_LK_CONF, CMD_LKDN_CONF, CMD_OTHER
  } fcsm_cmd_t;

  // what a bus read returns
  typedef enum logic [1:0] {
    SRC_ARRAY, SRC_STATUS, SRC_CONFIG, SRC_QUERY
  } fcsm_src_t;

  // write state machine states
  typedef enum logic [4:0] {
    ST_RD_ARRAY, ST_RD_STATUS, ST_RD_CONFIG, ST_RD_QUERY,
    ST_LK_SETUP, ST_LK_ERR, ST_LK_DONE,
    ST_PR_SETUP, ST_PR_BUSY, ST_PR_DONE,
    ST_PG_SETUP, ST_PG_BUSY, ST_PG_DONE,
    ST_PS_STATUS, ST_PS_ARRAY, ST_PS_CONFIG, ST_PS_QUERY,
    ST_ER_SETUP, ST_ER_ERR, ST_ER_BUSY, ST_ER_DONE,
    ST_ES_STATUS, ST_ES_ARRAY, ST_ES_CONFIG, ST_ES_QUERY,
    ST_ES_LOCK, ST_EP_SETUP, ST_EP_BUSY
  } fcsm_state_t;

  // one-cycle requests to the array algorithm
  typedef struct packed {
    logic prog_go;
    logic erase_go;
    logic susp_go;
    logic resume_go;
    logic lock_go;
    logic prot_go;
    logic clr_go;
  } fcsm_ctl_t;

  // complete state of the machine
  typedef struct packed {
    fcsm_state_t      st;
    fcsm_src_t        src;
    logic             ready;
    logic             prog_susp;
    logic             erase_susp;
    fcsm_ctl_t        ctl;
    logic [DATA_W-1:0] wdata;
  } fcsm_regs_t;

  // reset values
  localparam fcsm_ctl_t         CTL_NONE  = '0;
  localparam logic [DATA_W-1:0] WDATA_RST = 16'h0000;

endpackage
`default_nettype wire

//--- hw/fcsm_cmd_decode.sv
// maps a written command byte onto its command class
`timescale 1ns/1ps
`default_nettype none
module fcsm_cmd_decode
  import fcsm_pkg::*;
(
  input  wire logic [CODE_W-1:0] code,
  output fcsm_cmd_t              cmd
);

  // pure lookup, unknown bytes fall into a catch-all class
  always_comb begin
    unique case (code)
      CODE_READ_ARRAY:                cmd = CMD_RD_ARRAY;
      CODE_PROG_SETUP, CODE_PROG_ALT: cmd = CMD_PG_SETUP;
      CODE_ERASE_SETUP:               cmd = CMD_ER_SETUP;
      CODE_CONFIRM:                   cmd = CMD_CONFIRM;
      CODE_SUSPEND:                   cmd = CMD_SUSPEND;
      CODE_READ_STATUS:               cmd = CMD_RD_STATUS;
      CODE_CLR_STATUS:                cmd = CMD_CLR_STATUS;
      CODE_READ_CONFIG:               cmd = CMD_RD_CONFIG;
      CODE_READ_QUERY:                cmd = CMD_RD_QUERY;
      CODE_LOCK_SETUP:                cmd = CMD_LK_SETUP;
      CODE_PROT_SETUP:                cmd = CMD_PR_SETUP;
      CODE_LOCK_CONF:                 cmd = CMD_LK_CONF;
      CODE_LOCKDN_CONF:               cmd = CMD_LKDN_CONF;
      default:                        cmd = CMD_OTHER;
    endcase
  end

endmodule
`default_nettype wire

//--- verif/fcsm_algo_model.sv
// array algorithm stand-in answering start requests with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fcsm_algo_model
  import fcsm_pkg::*;
(
  input  wire logic       mclk,    // core clock
  input  wire fcsm_ctl_t  ctl,     // request pulses from the machine
  input  wire logic       sys_rst, // async reset, high
  input  wire logic [7:0] lat,     // cycles from start to done
  output logic            op_done  // finished pulse
);
  logic       run_reg; // an operation is running
  logic [7:0] cnt_reg; // cycles left
  // start, park on suspend, count down, pulse done
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      op_done <= 1'b0;
    end else begin
      op_done <= 1'b0;
      if (ctl.prog_go || ctl.erase_go || ctl.prot_go || ctl.resume_go) begin
        run_reg <= 1'b1;
        cnt_reg <= lat;
      end else if (ctl.susp_go) begin
        run_reg <= 1'b0; // parked, no done until resumed
      end else if (run_reg && cnt_reg <= 8'h01) begin
        run_reg <= 1'b0;
        op_done <= 1'b1;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/test_fcsm_top.sv
// self-checking bench of the flash command state machine
`timescale 1ns/1ps
`default_nettype none
module test_fcsm_top
  import fcsm_pkg::*;
;
  // expected answer to one write
  typedef struct packed {
    fcsm_src_t         src;
    logic              rdy;
    fcsm_ctl_t         ctl;
    logic              ps;
    logic              es;
    logic              chk;
    logic [DATA_W-1:0] dat;
  } fcsm_note_t;
  localparam logic       RDY   = 1'b1;
  localparam logic       BSY   = 1'b0;
  localparam fcsm_ctl_t  C0    = '0;
  localparam fcsm_ctl_t  CPG   = '{prog_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CER   = '{erase_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CSU   = '{susp_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CRS   = '{resume_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CLK   = '{lock_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CPR   = '{prot_go: 1'b1, default: 1'b0};
  localparam fcsm_ctl_t  CCL   = '{clr_go: 1'b1, default: 1'b0};
  localparam fcsm_note_t RST_N = '{src: SRC_ARRAY, rdy: 1'b1, ctl: '0, ps: 1'b0,
                                   es: 1'b0, chk: 1'b1, dat: '0};
  logic              mclk;              // core clock
  logic              sys_rst;           // async reset
  logic              wr_stb;            // write strobe
  logic [DATA_W-1:0] wr_data;           // written word
  logic              op_done;           // from the algorithm model
  logic [7:0]        lat;               // model latency
  fcsm_src_t         read_src;
  logic              machine_ready_bit;
  logic              prog_suspended;
  logic              erase_suspended;
  fcsm_ctl_t         ctl;
  logic [DATA_W-1:0] op_data;
  logic              stb_q = 1'b0;      // a write was taken last edge
  logic              ps_e;              // expected program parked
  logic              es_e;              // expected erase parked
  logic              chk_e;             // compare op_data too
  fcsm_note_t        notes[$];          // expected answers, oldest first
  int                fails;
  int                total_checks;

  fcsm_top dut (.mclk(mclk), .sys_rst(sys_rst), .wr_stb(wr_stb), .wr_data(wr_data),
    .op_done(op_done), .read_src(read_src), .machine_ready_bit(machine_ready_bit),
    .prog_suspended(prog_suspended), .erase_suspended(erase_suspended), .ctl(ctl),
    .op_data(op_data));
  fcsm_algo_model algo (.mclk(mclk), .ctl(ctl), .sys_rst(sys_rst), .lat(lat),
    .op_done(op_done));

  // 125 mhz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // count and print one mismatch
  task automatic bad(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  // compare one write answer with its note
  task automatic cmp_note(input fcsm_note_t n);
    total_checks++;
    if (read_src !== n.src || machine_ready_bit !== n.rdy || ctl !== n.ctl ||
        prog_suspended !== n.ps || erase_suspended !== n.es ||
        (n.chk && op_data !== n.dat)) begin
      bad($sformatf("write %h gave src %0d ready %b", n.dat, read_src, machine_ready_bit));
    end
  endtask

  // one bus write, its answer noted for the watcher
  task automatic wr(input logic [DATA_W-1:0] d, input fcsm_src_t s, input logic r,
                    input fcsm_ctl_t c);
    fcsm_note_t n;
    n = '{src: s, rdy: r, ctl: c, ps: ps_e, es: es_e, chk: chk_e, dat: d};
    notes.push_back(n);
    wr_stb  <= 1'b1;
    wr_data <= chk_e ? d : {8'($urandom), d[7:0]};
    @(posedge mclk);
  endtask

  // random non-suspend writes while busy change nothing
  task automatic busy_writes;
    logic [7:0] b;
    for (int j = 0; j < 4; j++) begin
      b = 8'($urandom);
      if (b == CODE_SUSPEND) b = CODE_READ_ARRAY;
      wr({8'h00, b}, SRC_STATUS, BSY, C0);
    end
  endtask

  // wait for done: busy until it, ready status after it
  task automatic wait_done;
    int k;
    wr_stb <= 1'b0;
    for (k = 0; k < 300 && op_done !== 1'b1; k++) begin
      @(posedge mclk);
    end
    total_checks++;
    if (k == 300 || machine_ready_bit !== BSY) bad("no done while busy");
    @(posedge mclk);
    total_checks++;
    if (machine_ready_bit !== RDY || read_src !== SRC_STATUS) bad("not ready after done");
  endtask

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watcher: each taken write has its answer one edge later
  always @(posedge mclk) begin
    if (stb_q) begin
      if (notes.size() == 0) bad("answer without note");
      else cmp_note(notes.pop_front());
    end
    stb_q <= wr_stb & ~sys_rst;
  end

  // hang guard
  initial begin
    #(8 * 20000);
    bad("watchdog expired");
    wrap_up();
  end

  // main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    wr_stb = 1'b0;
    wr_data = '0;
    lat = 8'h04;
    ps_e = 1'b0;
    es_e = 1'b0;
    chk_e = 1'b0;
    void'($urandom(32'h2cfa));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    cmp_note(RST_N);
    // idle decoding, back to back
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h0090, SRC_CONFIG, RDY, C0);
    wr(16'h0098, SRC_QUERY, RDY, C0);
    wr(16'h0050, SRC_ARRAY, RDY, CCL);
    wr(16'h0090, SRC_CONFIG, RDY, C0);
    wr(16'h0001, SRC_ARRAY, RDY, C0);
    wr(16'h0098, SRC_QUERY, RDY, C0);
    wr(16'h002F, SRC_ARRAY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h00D0, SRC_ARRAY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h00B0, SRC_ARRAY, RDY, C0);
    wr(16'h00A5, SRC_ARRAY, RDY, C0);
    // program with a suspend code as its data
    lat <= 8'h3C;
    wr(16'h0040, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'h00B0, SRC_STATUS, BSY, CPG);
    chk_e = 1'b0;
    busy_writes();
    wait_done();
    wr(16'h0090, SRC_CONFIG, RDY, C0);
    // program suspend and its reads
    lat <= 8'h02 + 8'($urandom % 20);
    wr(16'h0010, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'($urandom), SRC_STATUS, BSY, CPG);
    chk_e = 1'b0;
    ps_e = 1'b1;
    wr(16'h00B0, SRC_STATUS, RDY, CSU);
    wr(16'h00FF, SRC_ARRAY, RDY, C0);
    wr(16'h0090, SRC_CONFIG, RDY, C0);
    wr(16'h0098, SRC_QUERY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h0050, SRC_ARRAY, RDY, CCL);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h00B0, SRC_ARRAY, RDY, C0);
    wr(16'h0040, SRC_ARRAY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    ps_e = 1'b0;
    wr(16'h00D0, SRC_STATUS, BSY, CRS);
    wait_done();
    // erase setup errors, then erase
    wr(16'h0020, SRC_STATUS, RDY, C0);
    wr(16'h00FF, SRC_STATUS, RDY, C0);
    wr(16'h00FF, SRC_ARRAY, RDY, C0);
    wr(16'h0020, SRC_STATUS, RDY, C0);
    wr(16'h00B0, SRC_STATUS, RDY, C0);
    wr(16'h0098, SRC_QUERY, RDY, C0);
    wr(16'h0020, SRC_STATUS, RDY, C0);
    wr(16'h00FF, SRC_STATUS, RDY, C0);
    wr(16'h0040, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'h1234, SRC_STATUS, BSY, CPG);
    chk_e = 1'b0;
    wait_done();
    wr(16'h0020, SRC_STATUS, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h0020, SRC_STATUS, RDY, C0);
    lat <= 8'h3C;
    wr(16'h00D0, SRC_STATUS, BSY, CER);
    busy_writes();
    es_e = 1'b1;
    wr(16'h00B0, SRC_STATUS, RDY, CSU);
    // erase suspend decoding
    wr(16'h00FF, SRC_ARRAY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h0020, SRC_ARRAY, RDY, C0);
    wr(16'h0090, SRC_CONFIG, RDY, C0);
    wr(16'h0098, SRC_QUERY, RDY, C0);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h00C0, SRC_ARRAY, RDY, C0);
    wr(16'h0001, SRC_ARRAY, RDY, C0);
    wr(16'h002F, SRC_ARRAY, RDY, C0);
    wr(16'h0050, SRC_ARRAY, RDY, CCL);
    wr(16'h0070, SRC_STATUS, RDY, C0);
    wr(16'h0060, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'h0001, SRC_STATUS, RDY, CLK);
    chk_e = 1'b0;
    lat <= 8'h02 + 8'($urandom % 20);
    wr(16'h0040, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'($urandom), SRC_STATUS, BSY, CPG);
    chk_e = 1'b0;
    wait_done();
    wr(16'h00FF, SRC_ARRAY, RDY, C0);
    es_e = 1'b0;
    wr(16'h00D0, SRC_STATUS, BSY, CRS);
    wait_done();
    // lock from the erase done state, then protection from array read
    wr(16'h0060, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'h002F, SRC_STATUS, RDY, CLK);
    chk_e = 1'b0;
    wr(16'h0060, SRC_STATUS, RDY, C0);
    wr(16'h00FF, SRC_STATUS, RDY, C0);
    wr(16'h00FF, SRC_ARRAY, RDY, C0);
    lat <= 8'h3C;
    wr(16'h00C0, SRC_STATUS, RDY, C0);
    chk_e = 1'b1;
    wr(16'h0050, SRC_STATUS, BSY, CPR);
    chk_e = 1'b0;
    wr(16'h00B0, SRC_STATUS, BSY, C0);
    wait_done();
    // reset in the middle of an erase
    wr(16'h0020, SRC_STATUS, RDY, C0);
    wr(16'h00D0, SRC_STATUS, BSY, CER);
    wr_stb <= 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    cmp_note(RST_N);
    wrap_up();
  end
endmodule
`default_nettype wire
